// ### common/sndmix_consts.svh
// Register offsets, field positions and divider figures for the noise/mixer/envelope block
`ifndef SNDMIX_CONSTS_SVH
`define SNDMIX_CONSTS_SVH
// Register indices; the status index is our own read-only addition
`define IDX_NOISE_PERIOD 10'h006
`define IDX_MIXER_ENABLE 10'h007
`define IDX_AMPLITUDE_A 10'h008
`define IDX_AMPLITUDE_B 10'h009
`define IDX_AMPLITUDE_C 10'h00a
`define IDX_ENV_PERIOD_LOW 10'h00b
`define IDX_ENV_PERIOD_HIGH 10'h00c
`define IDX_ENV_SHAPE 10'h00d
`define IDX_ENV_STATUS 10'h00e
// Byte address is four times the index, one aligned word per register
`define OFF_NOISE_PERIOD {`IDX_NOISE_PERIOD, 2'b00}
`define OFF_MIXER_ENABLE {`IDX_MIXER_ENABLE, 2'b00}
`define OFF_AMPLITUDE_A {`IDX_AMPLITUDE_A, 2'b00}
`define OFF_AMPLITUDE_B {`IDX_AMPLITUDE_B, 2'b00}
`define OFF_AMPLITUDE_C {`IDX_AMPLITUDE_C, 2'b00}
`define OFF_ENV_PERIOD_LOW {`IDX_ENV_PERIOD_LOW, 2'b00}
`define OFF_ENV_PERIOD_HIGH {`IDX_ENV_PERIOD_HIGH, 2'b00}
`define OFF_ENV_SHAPE {`IDX_ENV_SHAPE, 2'b00}
`define OFF_ENV_STATUS {`IDX_ENV_STATUS, 2'b00}
`define NOISE_PRESCALE 16
`define ENV_PRESCALE 256
`define ENV_STEPS 16
`define NP_MSB 4
`define AMP_MODE_BIT 4
`define SHAPE_CONTINUE 3
`define SHAPE_ATTACK 2
`define SHAPE_ALTERNATE 1
`define SHAPE_HOLD 0
`define REG_RESET 8'h00
`define MIXER_RESET 8'hff
`endif

// ### common/sndmix_pkg.sv
// Types shared by the noise/mixer/envelope block
package sndmix_pkg;
	typedef struct packed {
		logic [3:0] level_c;
		logic [3:0] level_b;
		logic [3:0] level_a;
	} levels_s;
	typedef struct packed {
		logic out_c;
		logic out_b;
		logic out_a;
	} mix_s;
	typedef enum logic [1:0] {
		ENV_RUN,
		ENV_HOLD_LOW,
		ENV_HOLD_LAST
	} env_state_e;
endpackage

// ### rtl/sound_noise_mix_envelope.sv
// Noise divider, tone/noise mixer, amplitude select and envelope generator with APB registers
//
// Operation
// - Noise rate is the clock divided by sixteen and then by the noise period value.
// - The noise period value is bits four to zero of its register; upper bits are ignored.
// - Each mixer enable bit is active low: zero enables, one disables.
// - Mixer register bits five to three enable noise C,B,A and bits two to zero tone C,B,A.
// - Each channel mixes neither, either or both of its tone and the shared noise.
// - Each amplitude register uses bit four as mode and bits three to zero as fixed level.
// - The mode picks the fixed level or the envelope step value.
// - Each channel level is four bits wide, sixteen steps.
// - Envelope rate is the clock divided by 256 and then by the envelope period value.
// - The envelope period value is the high register over the low register.
// - The envelope steps a four-bit counter through sixteen states per cycle.
// - The shape selects count direction and single or repeated cycles.
// - Shape register bits: continue three, attack two, alternate one, hold zero.
//
// Implementation choice: the APB register port.
`timescale 1ns/1ps
`include "sndmix_consts.svh"

module sound_noise_mix_envelope #(
	parameter int LEVEL_W = 4,
	parameter int LFSR_W = 17
) (
	input wire logic MCLK,
	input wire logic NRST,
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [11:0] PADDR,
	input wire logic [31:0] PWDATA,
	output logic [31:0] PRDATA,
	output logic PREADY,
	output logic PSLVERR,
	input wire logic [2:0] TONE_IN,
	output logic [2:0] MIX_OUT,
	output logic [11:0] LEVEL_OUT,
	output logic NOISE_OUT
);
	logic [2:0] tone_s1_q;
	logic [2:0] tone_s2_q;
	logic [7:0] noise_period_q;
	logic [7:0] mixer_enable_q;
	logic [7:0] amp_q [3];
	logic [7:0] env_low_q;
	logic [7:0] env_high_q;
	logic [7:0] env_shape_q;
	logic shape_wr_q;
	logic [3:0] npre_q;
	logic [4:0] ncnt_q;
	logic [LFSR_W-1:0] lfsr_q;
	logic [7:0] epre_q;
	logic [15:0] ecnt_q;
	logic [3:0] estep_q;
	logic up_q;
	sndmix_pkg::env_state_e est_q;
	logic wr_en;
	logic rd_en;
	logic noise_tick;
	logic env_tick;
	logic [15:0] env_period;
	logic [4:0] noise_period_value;
	logic [3:0] envelope_step_value;
	wire sndmix_pkg::levels_s lv;
	wire sndmix_pkg::mix_s mx;

	// Converters take four-bit levels and the taps need at least five stages
	if (LEVEL_W != 4) begin : g_bad_level
		$error("LEVEL_W must be 4");
	end
	if (LFSR_W < 5) begin : g_bad_lfsr
		$error("LFSR_W too small");
	end

	// Address decode shared by read and write paths
	function automatic logic mapped(input logic [11:0] a);
		mapped = (a >= `OFF_NOISE_PERIOD) && (a <= `OFF_ENV_STATUS) && (a[1:0] == 2'b00);
	endfunction

	// Zero-wait APB slave; unmapped addresses answer with an error
	assign wr_en = PSEL && PENABLE && PWRITE;
	assign rd_en = PSEL && !PENABLE && !PWRITE;

	// Tone inputs come from another clock source, so synchronise
	always_ff @(posedge MCLK) begin
		tone_s1_q <= TONE_IN;
		tone_s2_q <= tone_s1_q;
	end

	// Register writes; shape write restarts the envelope
	always_ff @(posedge MCLK) begin
		if (!NRST) begin
			noise_period_q <= `REG_RESET;
			mixer_enable_q <= `MIXER_RESET;
			amp_q[0] <= `REG_RESET;
			amp_q[1] <= `REG_RESET;
			amp_q[2] <= `REG_RESET;
			env_low_q <= `REG_RESET;
			env_high_q <= `REG_RESET;
			env_shape_q <= `REG_RESET;
			shape_wr_q <= 1'b0;
		end else begin
			shape_wr_q <= 1'b0;
			if (wr_en) begin
				if (PADDR == `OFF_NOISE_PERIOD) begin
					noise_period_q <= PWDATA[7:0];
				end else if (PADDR == `OFF_MIXER_ENABLE) begin
					mixer_enable_q <= PWDATA[7:0];
				end else if (PADDR == `OFF_AMPLITUDE_A) begin
					amp_q[0] <= PWDATA[7:0];
				end else if (PADDR == `OFF_AMPLITUDE_B) begin
					amp_q[1] <= PWDATA[7:0];
				end else if (PADDR == `OFF_AMPLITUDE_C) begin
					amp_q[2] <= PWDATA[7:0];
				end else if (PADDR == `OFF_ENV_PERIOD_LOW) begin
					env_low_q <= PWDATA[7:0];
				end else if (PADDR == `OFF_ENV_PERIOD_HIGH) begin
					env_high_q <= PWDATA[7:0];
				end else if (PADDR == `OFF_ENV_SHAPE) begin
					env_shape_q <= PWDATA[7:0];
					shape_wr_q <= 1'b1;
				end
			end
		end
	end

	// Read data registered in the setup cycle so it is ready at the access edge
	always_ff @(posedge MCLK) begin
		if (!NRST) begin
			PRDATA <= 32'h0;
			PSLVERR <= 1'b0;
			PREADY <= 1'b0;
		end else begin
			PREADY <= PSEL && !PENABLE;
			PSLVERR <= PSEL && !PENABLE && !mapped(PADDR);
			if (rd_en) begin
				PRDATA <= 32'h0;
				if (PADDR == `OFF_NOISE_PERIOD) begin
					PRDATA[7:0] <= noise_period_q;
				end else if (PADDR == `OFF_MIXER_ENABLE) begin
					PRDATA[7:0] <= mixer_enable_q;
				end else if (PADDR == `OFF_AMPLITUDE_A) begin
					PRDATA[7:0] <= amp_q[0];
				end else if (PADDR == `OFF_AMPLITUDE_B) begin
					PRDATA[7:0] <= amp_q[1];
				end else if (PADDR == `OFF_AMPLITUDE_C) begin
					PRDATA[7:0] <= amp_q[2];
				end else if (PADDR == `OFF_ENV_PERIOD_LOW) begin
					PRDATA[7:0] <= env_low_q;
				end else if (PADDR == `OFF_ENV_PERIOD_HIGH) begin
					PRDATA[7:0] <= env_high_q;
				end else if (PADDR == `OFF_ENV_SHAPE) begin
					PRDATA[7:0] <= env_shape_q;
				end else if (PADDR == `OFF_ENV_STATUS) begin
					// Status is read only; writes to it are accepted and dropped
					PRDATA[7:0] <= {3'h0, up_q, estep_q};
				end
			end
		end
	end

	assign noise_period_value = noise_period_q[`NP_MSB:0];

	// Noise prescale by sixteen then period; zero period treated as one
	always_ff @(posedge MCLK) begin
		if (!NRST) begin
			npre_q <= 4'h0;
			ncnt_q <= 5'h0;
		end else begin
			npre_q <= npre_q + 4'h1;
			if (npre_q == 4'(`NOISE_PRESCALE - 1)) begin
				if (ncnt_q + 5'h1 >= noise_period_value)
					ncnt_q <= 5'h0;
				else
					ncnt_q <= ncnt_q + 5'h1;
			end
		end
	end
	assign noise_tick = (npre_q == 4'(`NOISE_PRESCALE - 1)) && (ncnt_q + 5'h1 >= noise_period_value);

	// Assertion helper: cycles since the last noise tick, and whether the period held meanwhile
	logic [9:0] nspan_q;
	logic nsteady_q;
	logic [9:0] nspan_exp;
	always_ff @(posedge MCLK) begin
		if (!NRST) begin
			nspan_q <= 10'h0;
			nsteady_q <= 1'b0;
		end else if (noise_tick) begin
			nspan_q <= 10'h0;
			nsteady_q <= 1'b1;
		end else begin
			nspan_q <= nspan_q + 10'h1;
			if (wr_en && PADDR == `OFF_NOISE_PERIOD)
				nsteady_q <= 1'b0;
		end
	end
	// Sixteen times the period, less one; period zero counts as one
	assign nspan_exp = {1'b0, (noise_period_value == 5'h0) ? 5'h0 : noise_period_value - 5'h1, 4'hf};

	// Pseudo-random noise shift register; taps chosen for a long sequence
	// Reset seeds a one and the XOR feedback never reaches all zeros from a nonzero state
	always_ff @(posedge MCLK) begin
		if (!NRST)
			lfsr_q <= {{(LFSR_W-1){1'b0}}, 1'b1};
		else if (noise_tick)
			lfsr_q <= {lfsr_q[0] ^ lfsr_q[3], lfsr_q[LFSR_W-1:1]};
	end

	// Period high byte over low byte
	assign env_period = {env_high_q, env_low_q};

	// Envelope prescale by 256 then period
	always_ff @(posedge MCLK) begin
		if (!NRST || shape_wr_q) begin
			epre_q <= 8'h0;
			ecnt_q <= 16'h0;
		end else begin
			epre_q <= epre_q + 8'h1;
			if (epre_q == 8'(`ENV_PRESCALE - 1)) begin
				if (ecnt_q + 16'h1 >= env_period)
					ecnt_q <= 16'h0;
				else
					ecnt_q <= ecnt_q + 16'h1;
			end
		end
	end
	assign env_tick = (epre_q == 8'(`ENV_PRESCALE - 1)) && (ecnt_q + 16'h1 >= env_period);

	always_ff @(posedge MCLK) begin
		if (!NRST) begin
			estep_q <= 4'h0;
			up_q <= 1'b0;
			est_q <= sndmix_pkg::ENV_HOLD_LOW;
		end else if (shape_wr_q) begin
			up_q <= env_shape_q[`SHAPE_ATTACK];
			estep_q <= env_shape_q[`SHAPE_ATTACK] ? 4'h0 : 4'hf;
			est_q <= sndmix_pkg::ENV_RUN;
		end else if (env_tick) begin
			case (est_q)
				sndmix_pkg::ENV_RUN: begin
					if (estep_q != (up_q ? 4'hf : 4'h0)) begin
						estep_q <= up_q ? estep_q + 4'h1 : estep_q - 4'h1;
					end else if (!env_shape_q[`SHAPE_CONTINUE]) begin
						estep_q <= 4'h0;
						est_q <= sndmix_pkg::ENV_HOLD_LOW;
					end else if (env_shape_q[`SHAPE_HOLD]) begin
						// Hold with alternate keeps the opposite end
						if (env_shape_q[`SHAPE_ALTERNATE])
							estep_q <= ~estep_q;
						est_q <= sndmix_pkg::ENV_HOLD_LAST;
					end else if (env_shape_q[`SHAPE_ALTERNATE]) begin
						up_q <= !up_q;
					end else begin
						estep_q <= up_q ? 4'h0 : 4'hf;
					end
				end
				// Holding states ignore ticks until the next shape write
				default: begin
					estep_q <= estep_q;
				end
			endcase
		end
	end
	assign envelope_step_value = estep_q;

	// Active-low enables, disabled path passes high
	generate
		for (genvar i = 0; i < 3; i++) begin : g_ch
			logic tone_pass;
			logic noise_pass;
			assign tone_pass = tone_s2_q[i] | mixer_enable_q[i];
			assign noise_pass = lfsr_q[0] | mixer_enable_q[i+3];
			assign mx[i] = tone_pass & noise_pass;
		end
	endgenerate

	// Mode bit picks envelope or fixed level
	assign lv.level_a = amp_q[0][`AMP_MODE_BIT] ? envelope_step_value : amp_q[0][3:0];
	assign lv.level_b = amp_q[1][`AMP_MODE_BIT] ? envelope_step_value : amp_q[1][3:0];
	assign lv.level_c = amp_q[2][`AMP_MODE_BIT] ? envelope_step_value : amp_q[2][3:0];

	// Outputs registered so converters see clean levels
	always_ff @(posedge MCLK) begin
		if (!NRST) begin
			MIX_OUT <= 3'h0;
			LEVEL_OUT <= 12'h0;
			NOISE_OUT <= 1'b0;
		end else begin
			MIX_OUT <= mx;
			LEVEL_OUT <= lv;
			NOISE_OUT <= lfsr_q[0];
		end
	end

	// Assertions
	fixed_level_a: assert property (@(posedge MCLK) disable iff (!NRST)
		!amp_q[0][4] |=> LEVEL_OUT[3:0] == $past(amp_q[0][3:0]))
		else $error("fixed level A wrong");
	env_level_a: assert property (@(posedge MCLK) disable iff (!NRST)
		amp_q[0][4] |=> LEVEL_OUT[3:0] == $past(estep_q))
		else $error("envelope level A wrong");
	mix_disable_a: assert property (@(posedge MCLK) disable iff (!NRST)
		&mixer_enable_q[5:0] |=> MIX_OUT == 3'h7)
		else $error("disabled mixer not high");
	tone_only_a: assert property (@(posedge MCLK) disable iff (!NRST)
		(mixer_enable_q[5:0] == 6'h38) |=> MIX_OUT == $past(tone_s2_q))
		else $error("tone path wrong");
	noise_span_a: assert property (@(posedge MCLK) disable iff (!NRST)
		noise_tick && nsteady_q |-> nspan_q == nspan_exp)
		else $error("noise tick spacing wrong");
	env_pre_a: assert property (@(posedge MCLK) disable iff (!NRST)
		epre_q != 8'hff |=> $stable(estep_q) || $past(shape_wr_q))
		else $error("envelope stepped off the prescale");
	fixed_level_c_a: assert property (@(posedge MCLK) disable iff (!NRST)
		!amp_q[2][4] |=> LEVEL_OUT[11:8] == $past(amp_q[2][3:0]))
		else $error("fixed level C wrong");
	env_hold_a: assert property (@(posedge MCLK) disable iff (!NRST)
		est_q == sndmix_pkg::ENV_HOLD_LAST && !shape_wr_q |=> $stable(estep_q))
		else $error("held envelope moved");
	apb_error_a: assert property (@(posedge MCLK) disable iff (!NRST)
		PSEL && !PENABLE && PADDR[1:0] != 2'b00 |=> PSLVERR && PREADY)
		else $error("misaligned access not refused");
	env_step_a: assert property (@(posedge MCLK) disable iff (!NRST)
		env_tick && !shape_wr_q && est_q == sndmix_pkg::ENV_RUN && up_q && estep_q != 4'hf
		|=> estep_q == $past(estep_q) + 4'h1)
		else $error("envelope step wrong");
	env_start_a: assert property (@(posedge MCLK) disable iff (!NRST)
		shape_wr_q |=> estep_q == ($past(env_shape_q[2]) ? 4'h0 : 4'hf))
		else $error("envelope start wrong");
	apb_ready_a: assert property (@(posedge MCLK) disable iff (!NRST)
		PSEL && !PENABLE |=> PREADY)
		else $error("no ready");

	// Covers for the main scenarios
	cover_hold: cover property (@(posedge MCLK) est_q == sndmix_pkg::ENV_HOLD_LAST);
	cover_triangle: cover property (@(posedge MCLK) env_tick && est_q == sndmix_pkg::ENV_RUN
		&& env_shape_q[`SHAPE_ALTERNATE] && !env_shape_q[`SHAPE_HOLD] && estep_q == 4'h0);
	cover_wrap: cover property (@(posedge MCLK) env_tick && estep_q == 4'hf);
	cover_noise: cover property (@(posedge MCLK) noise_tick);
endmodule

// ### testbench/host_apb.sv
// APB host model that loads the sound control registers
`timescale 1ns/1ps
module host_apb (
	input wire logic MCLK,
	output logic PSEL,
	output logic PENABLE,
	output logic PWRITE,
	output logic [11:0] PADDR,
	output logic [31:0] PWDATA,
	input wire logic [31:0] PRDATA,
	input wire logic PREADY,
	input wire logic PSLVERR
);
	// Bus idle from time zero
	initial begin
		PSEL = 1'b0;
		PENABLE = 1'b0;
		PWRITE = 1'b0;
		PADDR = 12'h000;
		PWDATA = 32'h0;
	end

	// Setup, access held until ready, then release
	// Address and data lines are inverted when idle so a stale value never looks valid
	task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d,
		output logic [31:0] rd, output logic err);
		PSEL <= 1'b1;
		PENABLE <= 1'b0;
		PWRITE <= wr;
		PADDR <= a;
		PWDATA <= d;
		@(posedge MCLK);
		PENABLE <= 1'b1;
		@(posedge MCLK);
		// Ready ends this wait; if it never comes, only the bench timeout does
		while (PREADY !== 1'b1) begin
			@(posedge MCLK);
		end
		rd = PRDATA;
		err = PSLVERR;
		PSEL <= 1'b0;
		PENABLE <= 1'b0;
		PADDR <= ~a;
		PWDATA <= ~d;
		@(posedge MCLK);
	endtask
endmodule

// ### testbench/tb_top.sv
// Self-checking bench for the noise, mixer, amplitude and envelope block
`timescale 1ns/1ps
`include "sndmix_consts.svh"
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin mismatches++; \
	$display("CHECK FAILED %s exp %0h got %0h", nm, e, g); end end
module tb_top;
	logic mclk = 1'b0;
	logic nrst = 1'b0;
	logic psel, penable, pwrite, pready, pslverr, noise, err, nb;
	logic [11:0] paddr, level;
	logic [31:0] pwdata, prdata, rd;
	logic [2:0] tone = 3'h0;
	logic [2:0] mix;
	logic [7:0] v;
	logic [7:0] masks [8] = '{8'h1f, 8'h3f, 8'h1f, 8'h1f, 8'h1f, 8'hff, 8'hff, 8'h0f};
	logic [3:0] shapes [10] = '{4'h0, 4'h4, 4'h8, 4'h9, 4'ha, 4'hb, 4'hc, 4'hd, 4'he, 4'hf};
	int checks = 0;
	int mismatches = 0;
	int cyc = 0;
	int n;
	integer seed = 32'hf200;

	sound_noise_mix_envelope u_dut (.MCLK(mclk), .NRST(nrst), .PSEL(psel), .PENABLE(penable),
		.PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
		.PSLVERR(pslverr), .TONE_IN(tone), .MIX_OUT(mix), .LEVEL_OUT(level), .NOISE_OUT(noise));
	host_apb u_host (.MCLK(mclk), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
		.PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr));

	always #2 mclk = ~mclk;

	// Cut a hang short; the envelope sweep dominates the run time
	always @(posedge mclk) begin
		cyc++;
		if (cyc > 80000) begin
			mismatches++;
			end_of_test;
		end
	end

	task automatic end_of_test;
		$display("checks %0d mismatches %0d", checks, mismatches);
		if (mismatches == 0 && checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	task automatic wr(input logic [11:0] a, input logic [7:0] d);
		u_host.xfer(1'b1, a, {24'h0, d}, rd, err);
	endtask

	task automatic rdr(input logic [11:0] a);
		u_host.xfer(1'b0, a, 32'h0, rd, err);
	endtask

	// Expected envelope step n steps after a shape write
	function automatic logic [3:0] env_exp(input logic [3:0] s, input int n);
		logic up;
		up = s[`SHAPE_ATTACK];
		if (n >= 16 && !s[`SHAPE_CONTINUE])
			return 4'h0;
		if (n >= 16 && s[`SHAPE_HOLD])
			return (up ^ s[`SHAPE_ALTERNATE]) ? 4'hf : 4'h0;
		if (s[`SHAPE_ALTERNATE] && n >= 16 && n < 32)
			up = ~up;
		return up ? 4'(n) : 4'hf - 4'(n);
	endfunction

	// Step phase is pinned to the shape write; one step of slack is allowed all the same
	function automatic logic env_ok(input logic [3:0] s, input int n, input logic [3:0] g);
		return g === env_exp(s, n) || g === env_exp(s, n + 1);
	endfunction

	initial begin
		repeat (16) @(posedge mclk);
		nrst <= 1'b1;
		@(posedge mclk);
		// Reset values, then random write and read-back of the used bits
		for (int i = 0; i < 8; i++) begin
			rdr(12'h018 + 12'(4 * i));
			`CHK("reset", (i == 1) ? 8'h3f : 8'h00, rd[7:0] & masks[i])
			v = 8'($random(seed));
			wr(12'h018 + 12'(4 * i), v);
			rdr(12'h018 + 12'(4 * i));
			`CHK("readback", v & masks[i], rd[7:0] & masks[i])
		end
		rdr(12'h03c);
		`CHK("unmapped_err", 1'b1, err)
		`CHK("unmapped_data", 32'h0, rd)
		wr(12'h019, 8'h1f);
		`CHK("misaligned_err", 1'b1, err)
		$display("test registers done");
		// Mixer: disabled paths count as high, corners first then random
		wr(`OFF_NOISE_PERIOD, 8'h1f);
		for (int i = 0; i < 24; i++) begin
			v = (i == 0) ? 8'h00 : (i == 1) ? 8'hff : (i == 2) ? 8'h38 : 8'($random(seed));
			tone <= 3'($random(seed));
			wr(`OFF_MIXER_ENABLE, v);
			repeat (3) @(posedge mclk);
			nb = noise;
			repeat (4) @(posedge mclk);
			if (nb === noise)
				`CHK("mix", (tone | v[2:0]) & ({3{noise}} | v[5:3]), mix)
		end
		$display("test mixer done");
		// Noise edges land on multiples of sixteen times the period; upper bits ignored
		wr(`OFF_NOISE_PERIOD, 8'he2);
		nb = noise;
		for (int k = 0; k < 7; k++) begin
			n = 0;
			@(posedge mclk);
			while (noise === nb && n < 4000) begin
				@(posedge mclk);
				n++;
			end
			nb = noise;
			if (k > 1)
				`CHK("noise_gap", 0, (n + 1) % 32)
		end
		$display("test noise done");
		wr(`OFF_AMPLITUDE_A, 8'he3);
		wr(`OFF_AMPLITUDE_B, 8'h0c);
		wr(`OFF_AMPLITUDE_C, 8'h6f);
		repeat (3) @(posedge mclk);
		`CHK("fixed", 12'hfc3, level)
		$display("test fixed levels done");
		// Every shape family on channel A while channel B keeps its fixed level
		wr(`OFF_AMPLITUDE_A, 8'h10);
		wr(`OFF_ENV_PERIOD_LOW, 8'h01);
		wr(`OFF_ENV_PERIOD_HIGH, 8'h00);
		foreach (shapes[j]) begin
			wr(`OFF_ENV_SHAPE, {4'hf, shapes[j]});
			repeat (4) @(posedge mclk);
			`CHK("env_start", 1'b1, env_ok(shapes[j], 0, level[3:0]))
			// Status shows direction and step while the first step still stands
			rdr(`OFF_ENV_STATUS);
			`CHK("env_status", {shapes[j][`SHAPE_ATTACK], env_exp(shapes[j], 0)}, rd[4:0])
			repeat (4900) @(posedge mclk);
			`CHK("env_late", 1'b1, env_ok(shapes[j], 19, level[3:0]))
			`CHK("chan_b", 4'hc, level[7:4])
		end
		$display("test envelope done");
		end_of_test;
	end
endmodule
